// ---- include/exc_prio_pkg.sv ----
// Purpose: shared constants and carriers for the exception priority unit
// Assumes: one core clock, avalon-mm register access
// Notes: priority levels are lower-is-more-urgent
package exc_prio_pkg;
  // register word offsets (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ERRCODE = 4'h8;
  localparam logic [3:0] REG_PENDING = 4'hC;
  // control field positions
  localparam int CTRL_IF = 0;
  localparam int CTRL_TS = 1;
  localparam int CTRL_MP = 2;
  localparam int CTRL_EM = 3;
  localparam int CTRL_NE = 4;
  localparam int CTRL_PROT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam int NUM_LEVELS = 15;
  // priority levels
  localparam logic [3:0] LVL_WARM_RESET = 4'h0;
  localparam logic [3:0] LVL_DBG_PREV = 4'h1;
  localparam logic [3:0] LVL_DBG_NEXT = 4'h2;
  localparam logic [3:0] LVL_FLUSH = 4'h3;
  localparam logic [3:0] LVL_SMI = 4'h4;
  localparam logic [3:0] LVL_NMI = 4'h5;
  localparam logic [3:0] LVL_MASKABLE_INT = 4'h6;
  localparam logic [3:0] LVL_FETCH = 4'h7;
  localparam logic [3:0] LVL_DECODE = 4'h8;
  localparam logic [3:0] LVL_WAIT_DNA = 4'h9;
  localparam logic [3:0] LVL_ESC_DNA = 4'hA;
  localparam logic [3:0] LVL_FPU_ERR = 4'hB;
  localparam logic [3:0] LVL_SEG = 4'hC;
  localparam logic [3:0] LVL_PAGE = 4'hD;
  localparam logic [3:0] LVL_ALIGN = 4'hE;
  localparam logic [3:0] LVL_NONE = 4'hF;
  // vectors
  localparam logic [7:0] VEC_DEBUG = 8'h01;
  localparam logic [7:0] VEC_NMI = 8'h02;
  localparam logic [7:0] VEC_INVALID_OP = 8'h06;
  localparam logic [7:0] VEC_DNA = 8'h07;
  localparam logic [7:0] VEC_DOUBLE = 8'h08;
  localparam logic [7:0] VEC_BAD_TSS = 8'h0A;
  localparam logic [7:0] VEC_NOT_PRESENT = 8'h0B;
  localparam logic [7:0] VEC_STACK = 8'h0C;
  localparam logic [7:0] VEC_GP = 8'h0D;
  localparam logic [7:0] VEC_PAGE = 8'h0E;
  localparam logic [7:0] VEC_FPU = 8'h10;
  localparam logic [7:0] VEC_ALIGN = 8'h11;
  localparam logic [7:0] VEC_NONE = 8'hFF;
  // error code layout
  localparam int EC_B0 = 0;
  localparam int EC_B1 = 1;
  localparam int EC_B2 = 2;
  localparam int EC_IDX_LSB = 3;
  // fault kinds for the memory stages
  typedef enum logic [2:0] {
    FK_NOT_PRESENT, FK_GP, FK_STACK, FK_BAD_TSS, FK_IDT
  } fault_kind_t;
  // descriptor of a segment/table fault
  typedef struct packed {
    fault_kind_t kind;
    logic [12:0] index;
    logic table_ind;
    logic during_handler;
  } seg_fault_t;
  // page fault causes
  typedef struct packed {
    logic protection;
    logic write;
    logic user;
  } page_fault_t;
  // chosen service
  typedef struct packed {
    logic [3:0] level;
    logic [7:0] vector;
    logic has_errcode;
    logic [15:0] errcode;
  } service_t;
endpackage

// ---- logic/exception_priority_errcode.sv ----
// Purpose: pick one interrupt or exception per instruction boundary, form error code
// Assumes: boundary strobe from the pipeline; sources hold until serviced
// Notes: What this block does
// What this block does
// - warm reset wins, level 0
// - previous-instruction debug level 1, next level 2
// - cache flush pin serviced at level 3
// - system management pin at level 4
// - nmi beats maskable interrupt, levels 5, 6
// - maskable interrupt only with enable flag set
// - fetch faults level 7, decode level 8
// - wait with task-switched and monitor flags: level 9
// - escape with emulate or task-switched: level 10
// - unmasked fpu error with enable: level 11
// - segment 12, page 13, alignment 14
// - only one exception per execution attempt
// - faults leave restartable state except partial tss
// - real mode never raises 13, 14
// - real mode vectors 8, 12, 13 mean overruns
// - protected mode error code for seven faults
// - error code pushed before handler entry
// - double fault, alignment code all zero
// - page fault code bits protection, write, user
// - table fault code: index, bit1 one, handler
// - segment code: index, table bit, zero, handler
`timescale 1ns/1ns
`default_nettype none
module exception_priority_errcode (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // external pins
  input wire logic i_warm_reset_in,
  input wire logic i_flush_n,
  input wire logic i_sys_mgmt_int_n,
  input wire logic i_nmi,
  input wire logic i_maskable_int,
  // pipeline events
  input wire logic i_boundary,
  input wire logic i_dbg_prev,
  input wire logic i_dbg_next,
  input wire logic i_fetch_fault,
  input wire exc_prio_pkg::seg_fault_t i_fetch_info,
  input wire logic i_decode_fault,
  input wire logic i_wait_instr,
  input wire logic i_fpu_escape_instr,
  input wire logic i_fpu_unmasked_err,
  input wire logic i_seg_fault,
  input wire exc_prio_pkg::seg_fault_t i_seg_info,
  input wire logic i_page_fault,
  input wire exc_prio_pkg::page_fault_t i_page_info,
  input wire logic i_align_fault,
  input wire logic i_double_fault,
  input wire logic i_int_table_overrun,
  input wire logic i_partial_tss,
  // avalon-mm slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // service result
  output logic o_take,
  output exc_prio_pkg::service_t o_service,
  output logic o_push_errcode,
  output logic o_restartable,
  output logic o_ack_flush,
  output logic o_ack_smi,
  output logic o_ack_nmi,
  output logic o_ack_maskable_int
);
  logic [5:0] ctrl_r;
  logic [2:0] wr_s1_r, wr_s2_r;
  logic [2:0] lv_s1_r, lv_s2_r;
  logic nmi_d_r, nmi_pend_r;
  logic done_r;
  logic [14:0] req;
  logic [3:0] win;
  exc_prio_pkg::service_t svc_nxt;
  logic prot, take;
  logic [15:0] seg_code, fetch_code;
  logic [7:0] seg_vec, fetch_vec;
  logic [15:0] count_r;

  // pin synchronisers: warm reset, flush, smi
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_s1_r <= 3'h6;
      wr_s2_r <= 3'h6;
    end else begin
      wr_s1_r <= {i_sys_mgmt_int_n, i_flush_n, i_warm_reset_in};
      wr_s2_r <= wr_s1_r;
    end
  end

  // nmi and maskable level synchronisers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lv_s1_r <= 3'h0;
      lv_s2_r <= 3'h0;
    end else begin
      lv_s1_r <= {1'b0, i_maskable_int, i_nmi};
      lv_s2_r <= lv_s1_r;
    end
  end

  // nmi is edge latched; the new edge wins over the service clear
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      nmi_d_r <= 1'b0;
      nmi_pend_r <= 1'b0;
    end else begin
      nmi_d_r <= lv_s2_r[0];
      if (lv_s2_r[0] && !nmi_d_r)
        nmi_pend_r <= 1'b1;
      else if (take && win == exc_prio_pkg::LVL_NMI)
        nmi_pend_r <= 1'b0;
    end
  end

  assign prot = ctrl_r[exc_prio_pkg::CTRL_PROT];

  // request vector indexed by level
  always_comb begin
    req = '0;
    req[exc_prio_pkg::LVL_WARM_RESET] = wr_s2_r[0];
    req[exc_prio_pkg::LVL_DBG_PREV] = i_dbg_prev;
    req[exc_prio_pkg::LVL_DBG_NEXT] = i_dbg_next;
    req[exc_prio_pkg::LVL_FLUSH] = !wr_s2_r[1];
    req[exc_prio_pkg::LVL_SMI] = !wr_s2_r[2];
    req[exc_prio_pkg::LVL_NMI] = nmi_pend_r;
    req[exc_prio_pkg::LVL_MASKABLE_INT] = lv_s2_r[1] && ctrl_r[exc_prio_pkg::CTRL_IF];
    req[exc_prio_pkg::LVL_FETCH] = i_fetch_fault;
    req[exc_prio_pkg::LVL_DECODE] = i_decode_fault;
    req[exc_prio_pkg::LVL_WAIT_DNA] = i_wait_instr && ctrl_r[exc_prio_pkg::CTRL_TS]
      && ctrl_r[exc_prio_pkg::CTRL_MP];
    req[exc_prio_pkg::LVL_ESC_DNA] = i_fpu_escape_instr && (ctrl_r[exc_prio_pkg::CTRL_EM]
      || ctrl_r[exc_prio_pkg::CTRL_TS]);
    req[exc_prio_pkg::LVL_FPU_ERR] = i_fpu_unmasked_err && ctrl_r[exc_prio_pkg::CTRL_NE];
    req[exc_prio_pkg::LVL_SEG] = i_seg_fault || i_double_fault || i_int_table_overrun;
    req[exc_prio_pkg::LVL_PAGE] = i_page_fault && prot;
    req[exc_prio_pkg::LVL_ALIGN] = i_align_fault && prot;
  end

  // lowest level wins
  always_comb begin
    win = exc_prio_pkg::LVL_NONE;
    for (int i = exc_prio_pkg::NUM_LEVELS - 1; i >= 0; i--) begin
      if (req[i])
        win = 4'(i);
    end
  end

  // one service per boundary; done_r blocks a repeat until the boundary ends
  assign take = i_boundary && !done_r && win != exc_prio_pkg::LVL_NONE;

  // segment / descriptor-table error code and vector
  function automatic logic [15:0] seg_errcode(input exc_prio_pkg::seg_fault_t f);
    logic [15:0] c;
    c = '0;
    c[15:exc_prio_pkg::EC_IDX_LSB] = f.index;
    c[exc_prio_pkg::EC_B0] = f.during_handler;
    if (f.kind == exc_prio_pkg::FK_IDT)
      c[exc_prio_pkg::EC_B1] = 1'b1;
    else
      c[exc_prio_pkg::EC_B2] = f.table_ind;
    return c;
  endfunction

  function automatic logic [7:0] seg_vector(input exc_prio_pkg::seg_fault_t f, input logic p);
    logic [7:0] v;
    v = exc_prio_pkg::VEC_GP;
    unique case (f.kind)
      exc_prio_pkg::FK_NOT_PRESENT: v = p ? exc_prio_pkg::VEC_NOT_PRESENT : exc_prio_pkg::VEC_GP;
      exc_prio_pkg::FK_STACK: v = exc_prio_pkg::VEC_STACK;
      exc_prio_pkg::FK_BAD_TSS: v = p ? exc_prio_pkg::VEC_BAD_TSS : exc_prio_pkg::VEC_GP;
      exc_prio_pkg::FK_GP, exc_prio_pkg::FK_IDT: v = exc_prio_pkg::VEC_GP;
      default: v = exc_prio_pkg::VEC_GP;
    endcase
    return v;
  endfunction

  assign seg_code = seg_errcode(i_seg_info);
  assign fetch_code = seg_errcode(i_fetch_info);
  assign seg_vec = seg_vector(i_seg_info, prot);
  assign fetch_vec = seg_vector(i_fetch_info, prot);

  // service descriptor for the winner
  always_comb begin
    svc_nxt = '0;
    svc_nxt.level = win;
    svc_nxt.vector = exc_prio_pkg::VEC_NONE;
    unique case (win)
      exc_prio_pkg::LVL_DBG_PREV, exc_prio_pkg::LVL_DBG_NEXT: svc_nxt.vector = exc_prio_pkg::VEC_DEBUG;
      exc_prio_pkg::LVL_NMI: svc_nxt.vector = exc_prio_pkg::VEC_NMI;
      exc_prio_pkg::LVL_FETCH: begin
        svc_nxt.vector = fetch_vec;
        svc_nxt.has_errcode = prot;
        svc_nxt.errcode = fetch_code;
      end
      exc_prio_pkg::LVL_DECODE: svc_nxt.vector = exc_prio_pkg::VEC_INVALID_OP;
      exc_prio_pkg::LVL_WAIT_DNA, exc_prio_pkg::LVL_ESC_DNA: svc_nxt.vector = exc_prio_pkg::VEC_DNA;
      exc_prio_pkg::LVL_FPU_ERR: svc_nxt.vector = exc_prio_pkg::VEC_FPU;
      exc_prio_pkg::LVL_SEG: begin
        if (i_double_fault || i_int_table_overrun) begin
          svc_nxt.vector = exc_prio_pkg::VEC_DOUBLE;
          svc_nxt.has_errcode = prot;
          svc_nxt.errcode = '0;
        end else begin
          svc_nxt.vector = seg_vec;
          svc_nxt.has_errcode = prot;
          svc_nxt.errcode = seg_code;
        end
      end
      exc_prio_pkg::LVL_PAGE: begin
        svc_nxt.vector = exc_prio_pkg::VEC_PAGE;
        svc_nxt.has_errcode = 1'b1;
        svc_nxt.errcode[exc_prio_pkg::EC_B2] = i_page_info.protection;
        svc_nxt.errcode[exc_prio_pkg::EC_B1] = i_page_info.write;
        svc_nxt.errcode[exc_prio_pkg::EC_B0] = i_page_info.user;
      end
      exc_prio_pkg::LVL_ALIGN: begin
        svc_nxt.vector = exc_prio_pkg::VEC_ALIGN;
        svc_nxt.has_errcode = 1'b1;
        svc_nxt.errcode = '0;
      end
      default: svc_nxt.vector = exc_prio_pkg::VEC_NONE;
    endcase
  end

  // boundary latch
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      done_r <= 1'b0;
    else if (!i_boundary)
      done_r <= 1'b0;
    else if (take)
      done_r <= 1'b1;
  end

  // registered service outputs
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_take <= 1'b0;
      o_service <= '0;
      o_push_errcode <= 1'b0;
      o_restartable <= 1'b1;
      o_ack_flush <= 1'b0;
      o_ack_smi <= 1'b0;
      o_ack_nmi <= 1'b0;
      o_ack_maskable_int <= 1'b0;
    end else begin
      o_take <= take;
      o_push_errcode <= take && svc_nxt.has_errcode;
      o_ack_flush <= take && win == exc_prio_pkg::LVL_FLUSH;
      o_ack_smi <= take && win == exc_prio_pkg::LVL_SMI;
      o_ack_nmi <= take && win == exc_prio_pkg::LVL_NMI;
      o_ack_maskable_int <= take && win == exc_prio_pkg::LVL_MASKABLE_INT;
      if (take) begin
        o_service <= svc_nxt;
        o_restartable <= !(win >= exc_prio_pkg::LVL_FETCH && i_partial_tss);
      end
    end
  end

  // count of services taken
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      count_r <= '0;
    else if (take)
      count_r <= count_r + 16'h0001;
  end

  // control register write
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      ctrl_r <= exc_prio_pkg::CTRL_RESET;
    else if (i_avs_write && i_avs_address == exc_prio_pkg::REG_CTRL && i_avs_byteenable[0])
      ctrl_r <= i_avs_writedata[5:0];
  end

  // zero-wait slave: readdata valid combinationally in the request cycle
  assign o_avs_waitrequest = 1'b0;
  always_comb begin
    o_avs_readdata = 32'h0000_0000;
    if (i_avs_read) begin
      unique case (i_avs_address)
        exc_prio_pkg::REG_CTRL: o_avs_readdata = {26'h0, ctrl_r};
        exc_prio_pkg::REG_STATUS: o_avs_readdata = {count_r, 2'h0, o_restartable,
          o_service.has_errcode, o_service.level, o_service.vector};
        exc_prio_pkg::REG_ERRCODE: o_avs_readdata = {16'h0, o_service.errcode};
        exc_prio_pkg::REG_PENDING: o_avs_readdata = {17'h0, req};
        default: o_avs_readdata = 32'h0000_0000;
      endcase
    end
  end
endmodule // exception_priority_errcode
`default_nettype wire

// ---- test/exception_priority_errcode_monitor.sv ----
// Purpose: port-level checks of service choice and error codes
// Assumes: take follows the sampling edge by one cycle
// Notes: bound into the unit from the bench top file
`timescale 1ns/1ns
`default_nettype none
module exception_priority_errcode_monitor (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // watched inputs
  input wire logic i_boundary,
  input wire logic i_dbg_prev,
  input wire logic i_partial_tss,
  input wire logic i_double_fault,
  input wire logic i_int_table_overrun,
  input wire exc_prio_pkg::seg_fault_t i_seg_info,
  input wire exc_prio_pkg::page_fault_t i_page_info,
  // watched outputs
  input wire logic o_take,
  input wire exc_prio_pkg::service_t o_service,
  input wire logic o_push_errcode,
  input wire logic o_restartable,
  input wire logic o_ack_nmi,
  input wire logic o_ack_maskable_int
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  property p_one_take; o_take |=> !o_take; endproperty
  a_one_take: assert property (p_one_take) else $error("take twice in a row");
  property p_at_bnd; o_take |-> $past(i_boundary); endproperty
  a_at_bnd: assert property (p_at_bnd) else $error("take without boundary");
  property p_dbg; o_take && $past(i_dbg_prev) |-> o_service.level <= exc_prio_pkg::LVL_DBG_PREV; endproperty
  a_dbg: assert property (p_dbg) else $error("debug event outranked");
  property p_page;
    o_take && o_service.level == exc_prio_pkg::LVL_PAGE |-> o_service.vector == exc_prio_pkg::VEC_PAGE
      && o_service.errcode == {13'h0000, $past(i_page_info)};
  endproperty
  a_page: assert property (p_page) else $error("page code wrong");
  property p_seg;
    o_take && o_service.level == exc_prio_pkg::LVL_SEG && o_service.has_errcode && !$past(i_double_fault)
      && !$past(i_int_table_overrun) && $past(i_seg_info.kind) != exc_prio_pkg::FK_IDT
      |-> o_service.errcode == {$past(i_seg_info.index), $past(i_seg_info.table_ind), 1'b0,
      $past(i_seg_info.during_handler)};
  endproperty
  a_seg: assert property (p_seg) else $error("segment code wrong");
  property p_zero;
    o_take && o_service.has_errcode && (o_service.level == exc_prio_pkg::LVL_ALIGN
      || o_service.vector == exc_prio_pkg::VEC_DOUBLE) |-> o_service.errcode == 16'h0000;
  endproperty
  a_zero: assert property (p_zero) else $error("code not zero");
  property p_push; o_push_errcode |-> o_take && o_service.has_errcode; endproperty
  a_push: assert property (p_push) else $error("push without take");
  property p_nmi; o_ack_nmi |-> o_take && o_service.level == exc_prio_pkg::LVL_NMI; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi ack wrong");
  property p_maskable_int; o_ack_maskable_int |-> o_take && o_service.level == exc_prio_pkg::LVL_MASKABLE_INT; endproperty
  a_maskable_int: assert property (p_maskable_int) else $error("maskable_int ack wrong");
  property p_rst; $fell(o_restartable) |-> o_take && $past(i_partial_tss); endproperty
  a_rst: assert property (p_rst) else $error("restartable dropped");
  c_warm: cover property (o_take && o_service.level == exc_prio_pkg::LVL_WARM_RESET);
  c_push: cover property (o_push_errcode);
  c_fell: cover property ($fell(o_restartable));
endmodule // exception_priority_errcode_monitor
`default_nettype wire

// ---- test/exception_priority_errcode_test.sv ----
// Purpose: self-checking bench for the exception priority unit
// Assumes: pipeline sources hold until the bench drops them
// Notes: random selector and page details from a fixed seed
`timescale 1ns/1ns
`default_nettype none
module exception_priority_errcode_test;
  logic i_clk, i_rstn, bnd_r, partial, dbl, rd_en, wr_en, took, pushed, take, push, restart, waitreq;
  logic ack_f, ack_s, ack_n, ack_i, warm, flush_n, smi_n, nmi, maskable_int, ovr;
  logic [14:0] pend;
  logic [3:0] addr;
  logic [31:0] wdat, rdat, readdata, ackv;
  exc_prio_pkg::seg_fault_t finfo, sinfo;
  exc_prio_pkg::page_fault_t pinfo;
  exc_prio_pkg::service_t svc;
  int err_count, num_checks, l, p;
  int cycles = 0;
  ext_sources src (.i_req({pend[6], pend[5], pend[4], pend[3], pend[0]}), .o_warm_reset_in(warm),
    .o_flush_n(flush_n), .o_sys_mgmt_int_n(smi_n), .o_nmi(nmi), .o_maskable_int(maskable_int));
  exception_priority_errcode dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_warm_reset_in(warm), .i_flush_n(flush_n),
    .i_sys_mgmt_int_n(smi_n), .i_nmi(nmi), .i_maskable_int(maskable_int), .i_boundary(bnd_r), .i_dbg_prev(pend[1]),
    .i_dbg_next(pend[2]), .i_fetch_fault(pend[7]), .i_fetch_info(finfo), .i_decode_fault(pend[8]),
    .i_wait_instr(pend[9]), .i_fpu_escape_instr(pend[10]), .i_fpu_unmasked_err(pend[11]),
    .i_seg_fault(pend[12]), .i_seg_info(sinfo), .i_page_fault(pend[13]), .i_page_info(pinfo),
    .i_align_fault(pend[14]), .i_double_fault(dbl), .i_int_table_overrun(ovr), .i_partial_tss(partial),
    .i_avs_address(addr), .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdat),
    .i_avs_byteenable(4'hF), .o_avs_readdata(readdata), .o_avs_waitrequest(waitreq), .o_take(take),
    .o_service(svc), .o_push_errcode(push), .o_restartable(restart), .o_ack_flush(ack_f),
    .o_ack_smi(ack_s), .o_ack_nmi(ack_n), .o_ack_maskable_int(ack_i));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    addr <= a;
    wdat <= d;
    wr_en <= 1'b1;
    do @(posedge i_clk); while (waitreq !== 1'b0);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    addr <= a;
    rd_en <= 1'b1;
    do @(posedge i_clk); while (waitreq !== 1'b0);
    d = readdata;
    rd_en <= 1'b0;
  endtask
  // one boundary; snapshot the one-cycle pulses where they stand
  task automatic bnd;
    int n;
    took = 1'b0;
    @(posedge i_clk) bnd_r <= 1'b1;
    for (n = 0; n < 8 && took !== 1'b1; n++) begin
      @(negedge i_clk);
      took = take;
      pushed = push;
      ackv = {28'h0, ack_i, ack_n, ack_s, ack_f};
    end
    @(posedge i_clk) bnd_r <= 1'b0;
  endtask
  function automatic logic [7:0] kvec(input exc_prio_pkg::seg_fault_t f, input logic prot);
    if (f.kind == exc_prio_pkg::FK_STACK) return exc_prio_pkg::VEC_STACK;
    if (f.kind == exc_prio_pkg::FK_NOT_PRESENT && prot) return exc_prio_pkg::VEC_NOT_PRESENT;
    if (f.kind == exc_prio_pkg::FK_BAD_TSS && prot) return exc_prio_pkg::VEC_BAD_TSS;
    return exc_prio_pkg::VEC_GP;
  endfunction
  function automatic logic [7:0] evec(input int lv, input logic prot);
    case (lv)
      1, 2: return exc_prio_pkg::VEC_DEBUG;
      5: return exc_prio_pkg::VEC_NMI;
      7: return kvec(finfo, prot);
      8: return exc_prio_pkg::VEC_INVALID_OP;
      9, 10: return exc_prio_pkg::VEC_DNA;
      11: return exc_prio_pkg::VEC_FPU;
      12: return kvec(sinfo, prot);
      13: return exc_prio_pkg::VEC_PAGE;
      14: return exc_prio_pkg::VEC_ALIGN;
      default: return exc_prio_pkg::VEC_NONE;
    endcase
  endfunction
  function automatic logic [15:0] eerr(input int lv);
    if (lv == 7 && finfo.kind == exc_prio_pkg::FK_IDT) return {finfo.index, 2'b01, finfo.during_handler};
    if (lv == 12 && sinfo.kind == exc_prio_pkg::FK_IDT) return {sinfo.index, 2'b01, sinfo.during_handler};
    if (lv == 7) return {finfo.index, finfo.table_ind, 1'b0, finfo.during_handler};
    if (lv == 12) return {sinfo.index, sinfo.table_ind, 1'b0, sinfo.during_handler};
    if (lv == 13) return {13'h0000, pinfo};
    return 16'h0000;
  endfunction
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      results();
    end
  end
  initial begin
    i_rstn = 1'b0; bnd_r = 1'b0; pend = '0; partial = 1'b1; dbl = 1'b0; ovr = 1'b0; rd_en = 1'b0; wr_en = 1'b0;
    addr = '0; wdat = '0; finfo = '0; sinfo = '0; pinfo = '0; err_count = 0; num_checks = 0;
    void'($urandom(14));
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(exc_prio_pkg::REG_CTRL, rdat);
    chk(rdat, {26'h0, exc_prio_pkg::CTRL_RESET});
    rd(4'h2, rdat);
    chk(rdat, 32'h0);
    for (p = 1; p >= 0; p--) begin
      wr(exc_prio_pkg::REG_CTRL, p ? 32'h37 : 32'h17);
      rd(exc_prio_pkg::REG_CTRL, rdat);
      chk(rdat, p ? 32'h37 : 32'h17);
      @(posedge i_clk) pend <= 15'h7FFF;
      repeat (4) @(posedge i_clk);
      // all sources pending, each boundary must take the most urgent left, except levels 13 and 14 in the real pass
      for (l = 0; l < 15; l++) begin
        @(posedge i_clk);
        finfo <= exc_prio_pkg::seg_fault_t'({3'($urandom_range(0, 4)), 15'($urandom)});
        sinfo <= exc_prio_pkg::seg_fault_t'({3'($urandom_range(0, 4)), 15'($urandom)});
        pinfo <= 3'($urandom);
        bnd();
        chk(took, (p == 0 && l > 12) ? 1'b0 : 1'b1);
        if (took) begin
          chk(svc.level, l);
          chk(svc.vector, evec(l, p[0]));
          chk(ackv, {28'h0, l == 6, l == 5, l == 4, l == 3});
          chk(pushed, p == 1 && (l == 7 || l >= 12));
          if (p == 1 && (l == 7 || l >= 12)) chk(svc.errcode, eerr(l));
          chk(restart, l < 7);
        end
        @(posedge i_clk) pend[l] <= 1'b0;
        repeat (4) @(posedge i_clk);
      end
      // protected pass: double fault; real pass: table limit overrun
      @(posedge i_clk) begin
        dbl <= p[0];
        ovr <= !p[0];
      end
      bnd();
      chk(svc.vector, exc_prio_pkg::VEC_DOUBLE);
      chk(pushed, p == 1);
      if (p == 1) chk(svc.errcode, 32'h0);
      @(posedge i_clk) begin
        dbl <= 1'b0;
        ovr <= 1'b0;
      end
    end
    wr(exc_prio_pkg::REG_CTRL, 32'h20);
    @(posedge i_clk) pend[6] <= 1'b1;
    repeat (4) @(posedge i_clk);
    bnd();
    chk(took, 1'b0);
    wr(exc_prio_pkg::REG_CTRL, 32'h21);
    bnd();
    chk(svc.level, exc_prio_pkg::LVL_MASKABLE_INT);
    results();
  end
endmodule // exception_priority_errcode_test
bind exception_priority_errcode exception_priority_errcode_monitor mon (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_boundary(i_boundary), .i_dbg_prev(i_dbg_prev), .i_partial_tss(i_partial_tss),
  .i_double_fault(i_double_fault), .i_int_table_overrun(i_int_table_overrun), .i_seg_info(i_seg_info),
  .i_page_info(i_page_info), .o_take(o_take), .o_service(o_service), .o_push_errcode(o_push_errcode),
  .o_restartable(o_restartable), .o_ack_nmi(o_ack_nmi), .o_ack_maskable_int(o_ack_maskable_int));
`default_nettype wire

// ---- test/ext_sources.sv ----
// Purpose: pin-level model of the interrupt, reset and flush sources
// Assumes: bench raises requests by index, warm flush smi nmi maskable_int
// Notes: a request holds its pin until the bench drops it
`timescale 1ns/1ns
`default_nettype none
module ext_sources (
  // requests from the bench
  input wire logic [4:0] i_req,
  // pins toward the unit
  output logic o_warm_reset_in,
  output logic o_flush_n,
  output logic o_sys_mgmt_int_n,
  output logic o_nmi,
  output logic o_maskable_int
);
  assign o_warm_reset_in = i_req[0];
  assign o_flush_n = !i_req[1];
  assign o_sys_mgmt_int_n = !i_req[2];
  assign o_nmi = i_req[3];
  assign o_maskable_int = i_req[4];
endmodule // ext_sources
`default_nettype wire
